/* File: logic/sdrci_pkg.sv */
// Shared constants, command codes and address helpers for the SDRAM command interface
package sdrci_pkg;
	// =========================================================
	// Geometry
	localparam int BANKS     = 4;
	localparam int BA_W      = 2;
	localparam int ADDR_W    = 12;
	localparam int ROWS      = 4096;
	localparam int COL_MAX_W = 11;

	// =========================================================
	// Commands as {cs_n, ras_n, cas_n, we_n}
	localparam logic [3:0] CMD_MODE_LOAD = 4'h0;
	localparam logic [3:0] CMD_REFRESH   = 4'h1;
	localparam logic [3:0] CMD_PRE       = 4'h2;
	localparam logic [3:0] CMD_ACT       = 4'h3;
	localparam logic [3:0] CMD_WR        = 4'h4;
	localparam logic [3:0] CMD_RD        = 4'h5;
	localparam logic [3:0] CMD_BTERM     = 4'h6;
	localparam logic [3:0] CMD_NOP       = 4'h7;
	localparam int         CMD_CS_POS    = 3;
	localparam int         PRE_FLAG_POS  = 10;

	// =========================================================
	// Mode word fields
	localparam int         BL_LSB     = 0;
	localparam int         BL_W       = 3;
	localparam int         BTYPE_POS  = 3;
	localparam int         CL_LSB     = 4;
	localparam int         CL_W       = 3;
	localparam logic [2:0] BL_1       = 3'h0;
	localparam logic [2:0] BL_2       = 3'h1;
	localparam logic [2:0] BL_4       = 3'h2;
	localparam logic [2:0] BL_8       = 3'h3;
	localparam logic [2:0] BL_PAGE    = 3'h7;
	localparam logic [2:0] CL_2       = 3'h2;
	localparam logic [11:0] MODE_RESET = 12'h020;

	// =========================================================
	// Timing
	localparam int CLK_PERIOD_NS = 4;
	localparam int TRP_CYC       = 3;
	localparam int TRCD_CYC      = 3;
	localparam int TRFC_CYC      = 8;
	localparam int TMRD_CYC      = 2;
	localparam int REF_WINDOW_NS = 16000000;
	localparam int REFI_CYC      = REF_WINDOW_NS / ROWS / CLK_PERIOD_NS;

	// Power states of the device end
	typedef enum logic [4:0] {
		PWR_RUN     = 5'h01,
		PWR_SUSP    = 5'h02,
		PWR_PDN_PRE = 5'h04,
		PWR_PDN_ACT = 5'h08,
		PWR_SREF    = 5'h10
	} sdrci_pwr_e;

	// =========================================================
	// Width dependent helpers
	function automatic int col_bits(input int dw);
		return (dw == 4) ? 11 : (dw == 8) ? 10 : 9;
	endfunction : col_bits

	function automatic int mask_bits(input int dw);
		return (dw == 16) ? 2 : 1;
	endfunction : mask_bits

	// Column taken from the address pins at a read or write
	function automatic logic [COL_MAX_W-1:0] col_of(input logic [ADDR_W-1:0] a, input int dw);
		if (dw == 4)
			return {a[ADDR_W-1], a[PRE_FLAG_POS-1:0]};
		else if (dw == 8)
			return {1'b0, a[PRE_FLAG_POS-1:0]};
		return {2'b00, a[PRE_FLAG_POS-2:0]};
	endfunction : col_of

	// Address pins for a column, precharge flag left low
	function automatic logic [ADDR_W-1:0] addr_of_col(input logic [COL_MAX_W-1:0] c, input int dw);
		if (dw == 4)
			return {c[COL_MAX_W-1], 1'b0, c[PRE_FLAG_POS-1:0]};
		else if (dw == 8)
			return {2'b00, c[PRE_FLAG_POS-1:0]};
		return {3'b000, c[PRE_FLAG_POS-2:0]};
	endfunction : addr_of_col
endpackage : sdrci_pkg

/* File: logic/sdrci_if.sv */
// Pin bundle between the memory controller end and the memory device end
`timescale 1ns/100ps
interface sdrci_if
	import sdrci_pkg::*;
#(
	parameter int DW = 16
);
	localparam int MW = mask_bits(DW);

	logic          cke;
	logic          cs_n;
	logic          ras_n;
	logic          cas_n;
	logic          we_n;
	logic [BA_W-1:0]   ba;
	logic [ADDR_W-1:0] addr;
	logic [MW-1:0] dqm;
	logic [DW-1:0] dq_ctl_out;
	logic [DW-1:0] dq_ctl_oe;
	logic [DW-1:0] dq_dev_out;
	logic [DW-1:0] dq_dev_oe;
	logic [DW-1:0] dq;

	// Data wire level; an undriven bit reads low
	assign dq = (dq_ctl_oe & dq_ctl_out) | (dq_dev_oe & dq_dev_out);

	modport ctl (
		output cke, cs_n, ras_n, cas_n, we_n, ba, addr, dqm, dq_ctl_out, dq_ctl_oe,
		input  dq
	);
	modport dev (
		input  cke, cs_n, ras_n, cas_n, we_n, ba, addr, dqm, dq,
		output dq_dev_out, dq_dev_oe
	);
endinterface : sdrci_if

/* File: logic/sdrci_ctl.sv */
// Memory controller end: opens rows, issues single accesses, refreshes
`timescale 1ns/100ps
module sdrci_ctl
	import sdrci_pkg::*;
#(
	parameter int          DW        = 16,
	parameter logic [11:0] MODE_WORD = MODE_RESET
) (
	input  wire logic                 mclk,
	input  wire logic                 resetn,
	sdrci_if.ctl                      bus,
	input  wire logic                 req_valid,
	output logic                      req_ready,
	input  wire logic                 req_write,
	input  wire logic                 req_ap,
	input  wire logic [BA_W-1:0]      req_bank,
	input  wire logic [ADDR_W-1:0]    req_row,
	input  wire logic [COL_MAX_W-1:0] req_col,
	input  wire logic [DW-1:0]        req_wdata,
	input  wire logic [mask_bits(DW)-1:0] req_wmask,
	output logic [DW-1:0]             rd_data,
	output logic                      rd_valid
);
	localparam int CL = (MODE_WORD[CL_LSB +: CL_W] == CL_2) ? 2 : 3;

	typedef enum logic [8:0] {
		S_INIT = 9'h001,
		S_MRD  = 9'h002,
		S_IDLE = 9'h004,
		S_TRCD = 9'h008,
		S_RW   = 9'h010,
		S_CAP  = 9'h020,
		S_PRE  = 9'h040,
		S_TRP  = 9'h080,
		S_REF  = 9'h100
	} sdrci_cst_e;

	sdrci_cst_e               state;
	logic [3:0]               wcnt;
	logic                     t_write;
	logic                     t_ap;
	logic [BA_W-1:0]          t_bank;
	logic [COL_MAX_W-1:0]     t_col;
	logic [DW-1:0]            t_wdata;
	logic [mask_bits(DW)-1:0] t_wmask;
	logic [9:0]               refi_cnt;
	logic                     ref_due;
	logic                     ref_ack;

	// =========================================================
	// Refresh pacing
	// whole array in window
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			refi_cnt <= 10'(REFI_CYC - 1);
			ref_due  <= 1'b0;
		end else begin
			refi_cnt <= (refi_cnt == '0) ? 10'(REFI_CYC - 1) : refi_cnt - 10'h001;
			// A new tick beats the acknowledge of the old one
			if (refi_cnt == '0)
				ref_due <= 1'b1;
			else if (ref_ack)
				ref_due <= 1'b0;
		end
	end

	// =========================================================
	// Command sequencer; pins are registered, a NOP unless set
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			state   <= S_INIT;
			wcnt    <= '0;
			{t_write, t_ap, t_bank, t_col, t_wdata, t_wmask} <= '0;
			req_ready <= 1'b0;
			rd_data   <= '0;
			rd_valid  <= 1'b0;
			ref_ack   <= 1'b0;
			bus.cke   <= 1'b1;
			{bus.cs_n, bus.ras_n, bus.cas_n, bus.we_n} <= CMD_NOP;
			bus.ba    <= '0;
			bus.addr  <= '0;
			bus.dqm   <= '0;
			bus.dq_ctl_out <= '0;
			bus.dq_ctl_oe  <= '0;
		end else begin
			bus.cke <= 1'b1;
			{bus.cs_n, bus.ras_n, bus.cas_n, bus.we_n} <= CMD_NOP;
			bus.dq_ctl_oe <= '0;
			bus.dqm   <= '0;
			rd_valid  <= 1'b0;
			ref_ack   <= 1'b0;
			req_ready <= 1'b0;
			unique case (state)
				S_INIT: begin
					{bus.cs_n, bus.ras_n, bus.cas_n, bus.we_n} <= CMD_MODE_LOAD;
					bus.addr <= MODE_WORD;
					wcnt     <= 4'(TMRD_CYC);
					state    <= S_MRD;
				end
				S_MRD, S_TRP, S_REF: begin
					wcnt <= wcnt - 4'h1;
					if (wcnt == 4'h1)
						state <= S_IDLE;
				end
				S_IDLE: begin
					if (req_valid && req_ready) begin
						{t_write, t_ap, t_bank, t_col} <= {req_write, req_ap, req_bank, req_col};
						{t_wdata, t_wmask} <= {req_wdata, req_wmask};
						{bus.cs_n, bus.ras_n, bus.cas_n, bus.we_n} <= CMD_ACT;
						bus.ba   <= req_bank;
						bus.addr <= req_row;
						wcnt     <= 4'(TRCD_CYC - 1);
						state    <= S_TRCD;
					end else if (ref_due) begin
						{bus.cs_n, bus.ras_n, bus.cas_n, bus.we_n} <= CMD_REFRESH;
						ref_ack <= 1'b1;
						wcnt    <= 4'(TRFC_CYC);
						state   <= S_REF;
					end else
						req_ready <= 1'b1;
				end
				S_TRCD: begin
					wcnt <= wcnt - 4'h1;
					if (wcnt == 4'h1)
						state <= S_RW;
				end
				S_RW: begin
					bus.ba   <= t_bank;
					bus.addr <= addr_of_col(t_col, DW) | (ADDR_W'(t_ap) << PRE_FLAG_POS);
					if (t_write) begin
						{bus.cs_n, bus.ras_n, bus.cas_n, bus.we_n} <= CMD_WR;
						bus.dq_ctl_out <= t_wdata;
						bus.dq_ctl_oe  <= '1;
						bus.dqm        <= t_wmask;
						wcnt  <= 4'(TRP_CYC + 1);
						state <= t_ap ? S_TRP : S_PRE;
					end else begin
						{bus.cs_n, bus.ras_n, bus.cas_n, bus.we_n} <= CMD_RD;
						wcnt  <= 4'(CL + 1);
						state <= S_CAP;
					end
				end
				S_CAP: begin
					wcnt <= wcnt - 4'h1;
					if (wcnt == 4'h1) begin
						rd_data  <= bus.dq;
						rd_valid <= 1'b1;
						wcnt     <= 4'(TRP_CYC);
						state    <= t_ap ? S_TRP : S_PRE;
					end
				end
				S_PRE: begin
					{bus.cs_n, bus.ras_n, bus.cas_n, bus.we_n} <= CMD_PRE;
					bus.ba   <= t_bank;
					bus.addr <= '0;
					wcnt     <= 4'(TRP_CYC);
					state    <= S_TRP;
				end
			endcase
		end
	end
endmodule : sdrci_ctl

/* File: logic/sdrci_dev.sv */
// Memory device end: command decode, bank rows, bursts, clock gating
`timescale 1ns/100ps
// How it works
// - Sample all pins at rising edge only
// - Each live edge advances burst and outputs
// - Four banks, 4096 rows, width-set columns
// - Controller activates row before read/write
// - Activate: bank bits and row bits
// - Read/write address is first burst column
// - Burst 1,2,4,8 or page; terminate
// - Auto precharge closes row after burst
// - New column accepted on every cycle
// - Banks precharge independently of others
// - Automotive: refresh within 16ms, no self-refresh; the model still enters PWR_SREF on a refresh with the gate low
// - Clock gate high runs, low freezes
// - Gate low picks power-down, refresh or suspend
// - Gate asynchronous while powered down
// - Input buffers off in power-down
// - Controller may hold gate high
// - Chip select high ignores commands
// - Bursts and masking continue while deselected
// - Four strobes form the command code
// - Column bits per width; flag bit precharges
// - Precharge flag high closes all banks
// - Mask blocks writes, floats reads two later
// - Mode load stores address as opcode
module sdrci_dev
	import sdrci_pkg::*;
#(
	parameter int DW     = 16,
	parameter int SROW_W = 2,
	parameter int SCOL_W = 4
) (
	input  wire logic           mclk,
	input  wire logic           resetn,
	sdrci_if.dev                bus,
	output sdrci_pwr_e          pwr_state,
	output logic [BANKS-1:0]    bank_open,
	output logic [ADDR_W-1:0]   mode_word
);
	localparam int CW  = col_bits(DW);
	localparam int MW  = mask_bits(DW);
	localparam int LW  = DW / MW;
	localparam int SAW = BA_W + SROW_W + SCOL_W;
	localparam int PCW = 4;

	// =========================================================
	// Pin registers
	logic              cke_q;
	logic              cke_s1;
	logic              cke_s2;
	logic [3:0]        cmd_q;
	logic [BA_W-1:0]   ba_q;
	logic [ADDR_W-1:0] addr_q;
	logic [DW-1:0]     dq_q;
	logic [MW-1:0]     dqm_q;
	logic              bufs_on;

	assign bufs_on = (pwr_state == PWR_RUN) || (pwr_state == PWR_SUSP);

	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			// Gate idles high; a low reset value would fake a power-down entry at the first edge
			cke_q  <= 1'b1;
			cmd_q  <= CMD_NOP;
			ba_q   <= '0;
			addr_q <= '0;
			dq_q   <= '0;
			dqm_q  <= '0;
		end else begin
			cke_q <= bus.cke;
			dqm_q <= bus.dqm;
			dq_q  <= bus.dq;
			if (bufs_on) begin
				cmd_q  <= {bus.cs_n, bus.ras_n, bus.cas_n, bus.we_n};
				ba_q   <= bus.ba;
				addr_q <= bus.addr;
			end else
				cmd_q <= CMD_NOP;
		end
	end

	// Gate synchroniser used only while powered down or in self-refresh
	// treated asynchronously in power-down
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			cke_s1 <= 1'b1;
			cke_s2 <= 1'b1;
		end else begin
			cke_s1 <= bus.cke;
			cke_s2 <= cke_s1;
		end
	end

	// =========================================================
	// Command decode
	logic clk_run;
	logic dec_on;
	logic is_act;
	logic is_rd;
	logic is_wr;
	logic is_pre;
	logic is_bterm;
	logic is_mload;

	assign clk_run  = (pwr_state == PWR_RUN) && cke_q;
	assign dec_on   = clk_run && !cmd_q[CMD_CS_POS];
	assign is_act   = dec_on && (cmd_q == CMD_ACT);
	assign is_rd    = dec_on && (cmd_q == CMD_RD);
	assign is_wr    = dec_on && (cmd_q == CMD_WR);
	assign is_pre   = dec_on && (cmd_q == CMD_PRE);
	assign is_bterm = dec_on && (cmd_q == CMD_BTERM);
	assign is_mload = dec_on && (cmd_q == CMD_MODE_LOAD);

	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn)
			mode_word <= MODE_RESET;
		else if (is_mload)
			mode_word <= addr_q;
	end

	// =========================================================
	// Burst engine
	function automatic logic [CW-1:0] burst_last(input logic [BL_W-1:0] code);
		unique case (code)
			BL_1:    return '0;
			BL_2:    return CW'(1);
			BL_4:    return CW'(3);
			BL_8:    return CW'(7);
			default: return '1;
		endcase
	endfunction : burst_last

	// Wraps inside the burst block; a page wraps over the whole row
	function automatic logic [CW-1:0] seq_col(input logic [CW-1:0] start, input logic [CW-1:0] idx,
		input logic [CW-1:0] m, input logic ilv);
		logic [CW-1:0] low;
		low = ilv ? (start ^ idx) : CW'(start + idx);
		return (start & ~m) | (low & m);
	endfunction : seq_col

	logic                 bst_on;
	logic                 bst_wr;
	logic                 bst_ap;
	logic [BA_W-1:0]      bst_bank;
	logic [CW-1:0]        bst_start;
	logic [CW-1:0]        bst_idx;
	logic [CW-1:0]        blast;
	logic [COL_MAX_W-1:0] pin_col;
	logic [CW-1:0]        new_col;
	logic                 beat_go;
	logic                 beat_wr;
	logic [BA_W-1:0]      beat_bank;
	logic [CW-1:0]        beat_col;
	logic                 bst_end;

	assign blast   = burst_last(mode_word[BL_LSB +: BL_W]);
	assign pin_col = col_of(addr_q, DW);
	assign new_col = pin_col[CW-1:0];
	assign bst_end = clk_run && bst_on && (bst_idx == blast);

	// Beat of this edge: a fresh command wins over the running burst
	always_comb begin
		beat_go   = 1'b0;
		beat_wr   = bst_wr;
		beat_bank = bst_bank;
		beat_col  = seq_col(bst_start, bst_idx, blast, mode_word[BTYPE_POS]);
		if (is_rd || is_wr) begin
			beat_go   = 1'b1;
			beat_wr   = is_wr;
			beat_bank = ba_q;
			beat_col  = new_col;
		end else if (clk_run && bst_on && !is_bterm)
			beat_go = 1'b1;
	end

	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			bst_on    <= 1'b0;
			bst_wr    <= 1'b0;
			bst_ap    <= 1'b0;
			bst_bank  <= '0;
			bst_start <= '0;
			bst_idx   <= '0;
		end else if (is_rd || is_wr) begin
			bst_on    <= (blast != '0);
			bst_wr    <= is_wr;
			bst_ap    <= addr_q[PRE_FLAG_POS];
			bst_bank  <= ba_q;
			bst_start <= new_col;
			bst_idx   <= CW'(1);
		end else if (is_bterm || bst_end)
			bst_on <= 1'b0;
		else if (clk_run && bst_on)
			bst_idx <= CW'(bst_idx + CW'(1));
	end

	// =========================================================
	// Storage window and banks
	// bank, row and column select
	logic [DW-1:0]     mem [0:(1 << SAW)-1];
	logic [ADDR_W-1:0] open_row [0:BANKS-1];
	logic [PCW-1:0]    pre_cnt [0:BANKS-1];
	logic [SAW-1:0]    beat_idx;
	logic [BANKS-1:0]  pre_req;
	logic              ap_now;
	logic [BA_W-1:0]   ap_bank;

	assign beat_idx = {beat_bank, open_row[beat_bank][SROW_W-1:0], beat_col[SCOL_W-1:0]};

	always_comb begin
		ap_now  = 1'b0;
		ap_bank = bst_bank;
		if (bst_on && bst_ap && (bst_end || is_rd || is_wr || is_bterm))
			ap_now = 1'b1;
		else if ((is_rd || is_wr) && addr_q[PRE_FLAG_POS] && (blast == '0)) begin
			ap_now  = 1'b1;
			ap_bank = ba_q;
		end
		pre_req = ap_now ? (BANKS'(1) << ap_bank) : '0;
		if (is_pre)
			pre_req = pre_req | (addr_q[PRE_FLAG_POS] ? '1 : (BANKS'(1) << ba_q));
	end

	// each bank times its own precharge
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			bank_open <= '0;
			for (int b = 0; b < BANKS; b++) begin
				open_row[b] <= '0;
				pre_cnt[b]  <= '0;
			end
		end else begin
			for (int b = 0; b < BANKS; b++) begin
				if (is_act && (ba_q == BA_W'(b))) begin
					bank_open[b] <= 1'b1;
					open_row[b]  <= addr_q;
					pre_cnt[b]   <= '0;
				end else if (pre_req[b] && bank_open[b] && (pre_cnt[b] == '0))
					pre_cnt[b] <= PCW'(TRP_CYC);
				else if (pre_cnt[b] == PCW'(1)) begin
					bank_open[b] <= 1'b0;
					pre_cnt[b]   <= '0;
				end else if (pre_cnt[b] != '0)
					pre_cnt[b] <= pre_cnt[b] - PCW'(1);
			end
		end
	end

	always_ff @(posedge mclk) begin
		if (beat_go && beat_wr)
			for (int l = 0; l < MW; l++)
				if (!dqm_q[l])
					mem[beat_idx][l*LW +: LW] <= dq_q[l*LW +: LW];
	end

	// =========================================================
	// Read pipeline; frozen while the clock is suspended
	logic [DW-1:0] rd_d0;
	logic          rd_v0;
	logic          cl3;
	logic [DW-1:0] lane_on;

	assign cl3 = (mode_word[CL_LSB +: CL_W] != CL_2);

	// Two clocks after the mask edge the lanes float
	always_comb begin
		for (int l = 0; l < MW; l++)
			lane_on[l*LW +: LW] = {LW{!dqm_q[l]}};
	end

	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			{rd_d0, rd_v0} <= '0;
			bus.dq_dev_out <= '0;
			bus.dq_dev_oe  <= '0;
		end else if (clk_run) begin
			// Latency two drives the word of the command edge at once; three waits one stage
			rd_v0 <= beat_go && !beat_wr;
			rd_d0 <= mem[beat_idx];
			bus.dq_dev_out <= cl3 ? rd_d0 : mem[beat_idx];
			bus.dq_dev_oe  <= (cl3 ? rd_v0 : (beat_go && !beat_wr)) ? lane_on : '0;
		end
	end

	// =========================================================
	// Clock gate power states
	// state chosen by running burst, refresh command and open banks
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn)
			pwr_state <= PWR_RUN;
		else begin
			unique case (pwr_state)
				PWR_RUN:
					if (!cke_q) begin
						if (bst_on)
							pwr_state <= PWR_SUSP;
						else if (cmd_q == CMD_REFRESH)
							pwr_state <= PWR_SREF;
						else if (bank_open != '0)
							pwr_state <= PWR_PDN_ACT;
						else
							pwr_state <= PWR_PDN_PRE;
					end
				PWR_SUSP:
					if (cke_q)
						pwr_state <= PWR_RUN;
				PWR_PDN_PRE, PWR_PDN_ACT, PWR_SREF:
					if (cke_s2)
						pwr_state <= PWR_RUN;
				default:
					pwr_state <= PWR_RUN;
			endcase
		end
	end
endmodule : sdrci_dev

/* File: verif/sdrci_props.sv */
// Concurrent checks on the pins between the controller end and the device end
`timescale 1ns/100ps
module sdrci_props
	import sdrci_pkg::*;
#(
	parameter int                DW        = 16,
	parameter int                MW        = 2,
	parameter logic [ADDR_W-1:0] MODE_WORD = MODE_RESET
) (
	input wire logic              mclk,
	input wire logic              resetn,
	input wire logic              cke,
	input wire logic              cs_n,
	input wire logic              ras_n,
	input wire logic              cas_n,
	input wire logic              we_n,
	input wire logic [BA_W-1:0]   ba,
	input wire logic [ADDR_W-1:0] addr,
	input wire logic [MW-1:0]     dqm,
	input wire logic [DW-1:0]     dq_ctl_oe,
	input wire logic [DW-1:0]     dq_dev_oe
);
	logic [3:0] cmd;

	// =========================================================
	// Command code as registered by the device at each edge
	assign cmd = {cs_n, ras_n, cas_n, we_n};

	default clocking cb @(posedge mclk); endclocking
	default disable iff (!resetn);

	// =========================================================
	// Assertions
	// gate held high
	cke_high_a:
		assert property (cke)
		else $error("clock gate seen low");
	mode_first_a:
		assert property ($rose(resetn) |-> ##1 (cmd == CMD_MODE_LOAD && addr == MODE_WORD))
		else $error("first command is not a mode load");
	act_access_a:
		assert property (cmd == CMD_ACT |-> ##1 (cmd == CMD_NOP)[*2]
			##1 ((cmd == CMD_RD || cmd == CMD_WR) && ba == $past(ba, 3)))
		else $error("activate not followed by access to same bank");
	wr_drive_a:
		assert property (cmd == CMD_WR |-> (&dq_ctl_oe))
		else $error("write without controller data drive");
	rd_answer_a:
		assert property ((cmd == CMD_RD && dqm == '0) |-> ##2 (&dq_dev_oe))
		else $error("read data not driven two edges after read");
	dev_cause_a:
		assert property ((|dq_dev_oe) |-> $past(cmd, 2) == CMD_RD)
		else $error("device drives data without a read");
	bus_clash_a:
		assert property ((dq_ctl_oe & dq_dev_oe) == '0)
		else $error("both ends drive data together");
	pre_after_a:
		assert property (((cmd == CMD_RD || cmd == CMD_WR) && !addr[PRE_FLAG_POS])
			|-> ##[1:10] (cmd == CMD_PRE && !addr[PRE_FLAG_POS]))
		else $error("access without auto close not followed by precharge");
	ap_no_pre_a:
		assert property (((cmd == CMD_RD || cmd == CMD_WR) && addr[PRE_FLAG_POS])
			|-> ##1 (cmd != CMD_PRE)[*6])
		else $error("precharge issued after auto close access");

	// =========================================================
	// Coverage of the main transfers
	rd_c: cover property (cmd == CMD_RD ##2 (&dq_dev_oe));
	wr_c: cover property (cmd == CMD_WR && dqm != '0);
	ap_c: cover property (cmd == CMD_WR && addr[PRE_FLAG_POS]);
endmodule : sdrci_props

/* File: verif/sdrci_command_interface_tb_top.sv */
// Testbench joining both ends of the SDRAM command interface
`timescale 1ns/100ps
module sdrci_command_interface_tb_top
	import sdrci_pkg::*;
;
	localparam int DW = 16;
	// Differs from the reset word in unused bits, so a lost mode load shows
	localparam logic [11:0] MODE_BENCH = 12'h420;

	logic              mclk;
	logic              resetn;
	logic              req_valid;
	logic              req_ready;
	logic              req_write;
	logic              req_ap;
	logic [1:0]        req_bank;
	logic [11:0]       req_row;
	logic [10:0]       req_col;
	logic [15:0]       req_wdata;
	logic [1:0]        req_wmask;
	logic [15:0]       rd_data;
	logic              rd_valid;
	sdrci_pwr_e        pwr_state;
	logic [3:0]        bank_open;
	logic [11:0]       mode_word;
	int                cyc;
	int                fails;
	int                checks;

	// =========================================================
	// Ends, carrier and checker
	sdrci_if #(.DW(DW)) sdrci_if_i ();
	sdrci_ctl #(.DW(DW), .MODE_WORD(MODE_BENCH)) sdrci_ctl_i (.mclk(mclk), .resetn(resetn), .bus(sdrci_if_i.ctl),
		.req_valid(req_valid), .req_ready(req_ready), .req_write(req_write), .req_ap(req_ap),
		.req_bank(req_bank), .req_row(req_row), .req_col(req_col), .req_wdata(req_wdata),
		.req_wmask(req_wmask), .rd_data(rd_data), .rd_valid(rd_valid));
	sdrci_dev #(.DW(DW)) sdrci_dev_i (.mclk(mclk), .resetn(resetn), .bus(sdrci_if_i.dev),
		.pwr_state(pwr_state), .bank_open(bank_open), .mode_word(mode_word));
	sdrci_props #(.DW(DW), .MW(mask_bits(DW)), .MODE_WORD(MODE_BENCH)) sdrci_props_i (.mclk(mclk), .resetn(resetn),
		.cke(sdrci_if_i.cke), .cs_n(sdrci_if_i.cs_n), .ras_n(sdrci_if_i.ras_n),
		.cas_n(sdrci_if_i.cas_n), .we_n(sdrci_if_i.we_n), .ba(sdrci_if_i.ba),
		.addr(sdrci_if_i.addr), .dqm(sdrci_if_i.dqm), .dq_ctl_oe(sdrci_if_i.dq_ctl_oe),
		.dq_dev_oe(sdrci_if_i.dq_dev_oe));

	// =========================================================
	// Clock and hang guard; ceiling far above the roughly 1300 cycles needed
	always #2 mclk = ~mclk;

	always @(posedge mclk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			fails++;
			end_sim();
		end
	end

	// =========================================================
	// Tasks
	task automatic end_sim();
		$display("checks=%0d fails=%0d", checks, fails);
		if (fails == 0 && checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : end_sim

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		checks++;
		if (got !== exp) begin
			fails++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	// Bounded wait for the controller to accept a new request
	task automatic wait_idle();
		int n;
		n = 0;
		do begin
			@(posedge mclk);
			n++;
		end while (req_ready !== 1'b1 && n < 400);
	endtask : wait_idle

	// One single-word request held until taken; a read compares the returned word
	task automatic access(input logic wr, input logic ap, input logic [1:0] bk, input logic [11:0] row,
		input logic [10:0] col, input logic [15:0] wd, input logic [1:0] wm, input logic [15:0] exp);
		int n;
		// An edge passes first, so valid is never lowered and raised in one step
		@(posedge mclk);
		req_valid <= 1'b1;
		req_write <= wr;
		req_ap    <= ap;
		req_bank  <= bk;
		req_row   <= row;
		req_col   <= col;
		req_wdata <= wd;
		req_wmask <= wm;
		// Request stands until the edge where ready is seen with it
		n = 0;
		do begin
			@(posedge mclk);
			n++;
		end while (req_ready !== 1'b1 && n < 400);
		req_valid <= 1'b0;
		if (!wr) begin
			n = 0;
			do begin
				@(posedge mclk);
				n++;
			end while (rd_valid !== 1'b1 && n < 20);
			chk({15'h0000, rd_valid}, 16'h0001);
			chk(rd_data, exp);
		end
	endtask : access

	// =========================================================
	// Main sequence
	initial begin
		mclk = 1'b0;
		resetn = 1'b0;
		req_valid = 1'b0;
		req_write = 1'b0;
		req_ap = 1'b0;
		req_bank = 2'h0;
		req_row = 12'h000;
		req_col = 11'h000;
		req_wdata = 16'h0000;
		req_wmask = 2'h0;
		cyc = 0;
		fails = 0;
		checks = 0;
		repeat (16) @(posedge mclk);
		resetn <= 1'b1;
		wait_idle();
		chk({4'h0, mode_word}, {4'h0, MODE_BENCH});
		chk({11'h000, pwr_state}, {11'h000, PWR_RUN});
		for (int b = 0; b < 4; b++)
			access(1'b1, 1'b0, b[1:0], b[11:0], 11'h003, 16'hA5C0 | b[15:0], 2'h0, 16'h0000);
		for (int b = 0; b < 4; b++)
			access(1'b0, 1'b0, b[1:0], b[11:0], 11'h003, 16'h0000, 2'h0, 16'hA5C0 | b[15:0]);
		wait_idle();
		// The last bank closes one edge after the controller reports idle
		@(posedge mclk);
		chk({12'h000, bank_open}, 16'h0000);
		// byte lanes masked one at a time
		access(1'b1, 1'b0, 2'h0, 12'h000, 11'h003, 16'h1234, 2'h2, 16'h0000);
		access(1'b0, 1'b0, 2'h0, 12'h000, 11'h003, 16'h0000, 2'h0, 16'hA534);
		access(1'b1, 1'b0, 2'h0, 12'h000, 11'h003, 16'h5678, 2'h1, 16'h0000);
		access(1'b0, 1'b0, 2'h0, 12'h000, 11'h003, 16'h0000, 2'h0, 16'h5634);
		access(1'b1, 1'b1, 2'h2, 12'h003, 11'h1FF, 16'hBEEF, 2'h0, 16'h0000);
		wait_idle();
		@(posedge mclk);
		chk({12'h000, bank_open}, 16'h0000);
		access(1'b0, 1'b1, 2'h2, 12'h003, 11'h1FF, 16'h0000, 2'h0, 16'hBEEF);
		for (int c = 0; c < 4; c++)
			access(1'b1, 1'b0, 2'h1, 12'h002, c[10:0], 16'h3C00 + c[15:0], 2'h0, 16'h0000);
		for (int c = 3; c >= 0; c--)
			access(1'b0, 1'b0, 2'h1, 12'h002, c[10:0], 16'h0000, 2'h0, 16'h3C00 + c[15:0]);
		// a refresh falls in this idle stretch; stored data must survive it
		repeat (1000) @(posedge mclk);
		access(1'b0, 1'b0, 2'h0, 12'h000, 11'h003, 16'h0000, 2'h0, 16'h5634);
		chk({11'h000, pwr_state}, {11'h000, PWR_RUN});
		end_sim();
	end
endmodule : sdrci_command_interface_tb_top
